//--- verilog/spi_ctrl_pkg.sv
// package for the synchronous serial port control block in spi mode
// assumes a 10 MHz system clock and an apb master reaching the registers
//
// Behaviour
// - low four bits of control register select port operating mode
// - mode 0101: slave on serial clock pin, slave select ignored
// - mode 0100: slave on serial clock pin, slave select gates it
// - mode 0011: master, serial clock is second timer output halved
// - mode 0010: master, serial clock is system clock over sixty-four
// - clock polarity bit sets serial clock idle level, 1 high
package spi_ctrl_pkg;
  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_DATA = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [11:0] ADDR_IEN = 12'h00c;
  localparam logic [11:0] ADDR_ICLR = 12'h010;
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int BIT_COLL = 7;
  localparam int BIT_OVF = 6;
  localparam int BIT_EN = 5;
  localparam int BIT_CKP = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h3f;
  // ---------------------------------------------------------------
  // mode codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_MST_TMR = 4'h3;
  localparam logic [3:0] MODE_MST_DIV = 4'h2;
  // ---------------------------------------------------------------
  // timing: half serial period in system clocks for the /64 mode
  // ---------------------------------------------------------------
  localparam int FOSC_DIV = 64;
  localparam logic [4:0] HALF_DIV_LAST = 5'(FOSC_DIV / 2 - 1);
  // interrupt status bits
  localparam int IRQ_COLL = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_W = 3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } shift_state_t;
endpackage : spi_ctrl_pkg

//--- verilog/spi_clock_gen.sv
// serial clock tick generator for master modes
// assumes the second timer output arrives as a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module spi_clock_gen (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic run,
  input wire logic useTimer,
  input wire logic timerPulse,
  output logic halfTick
);
  logic [4:0] divCnt_reg, divCnt_next;
  // ---------------------------------------------------------------
  // tick every half serial period
  // ---------------------------------------------------------------
  always_comb begin
    divCnt_next = divCnt_reg;
    halfTick = 1'b0;
    if (!run) begin
      divCnt_next = 5'h00;
    end else if (useTimer) begin
      // two timer pulses per serial period give output/2
      halfTick = timerPulse;
    end else if (divCnt_reg == spi_ctrl_pkg::HALF_DIV_LAST) begin
      divCnt_next = 5'h00;
      halfTick = 1'b1;
    end else begin
      divCnt_next = divCnt_reg + 5'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      divCnt_reg <= 5'h00;
    end else if (clkEn) begin
      divCnt_reg <= divCnt_next;
    end
  end
endmodule : spi_clock_gen
`default_nettype wire

//--- verilog/sync_serial_spi_control.sv
// control, mode selection and shifter of the synchronous serial port
// assumes apb master on clk_sys; serial pins synchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
module sync_serial_spi_control (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timerPulse,
  input wire logic sckIn,
  input wire logic sdi,
  input wire logic slaveSelN,
  output logic sckOut,
  output logic sdo,
  output logic portEnable,
  output logic irq
);
  localparam int IW = spi_ctrl_pkg::IRQ_W;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] rxBuf_reg, rxBuf_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic bufFull_reg, bufFull_next;
  logic sckOut_reg, sckOut_next;
  logic sdo_reg, sdo_next;
  logic sckInOld_reg, sckInOld_next;
  logic [IW-1:0] stat_reg, stat_next, ien_reg, ien_next;
  logic [31:0] prdata_reg, prdata_next;
  logic irq_reg, irq_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  spi_ctrl_pkg::shift_state_t st_reg, st_next;
  logic halfTick, isMaster, isSlave, ssGate, access, wrData, rdData;
  logic sckEdge, sampleEdge, shiftEdge;
  logic [3:0] mode;
  assign mode = ctrl_reg[3:0];
  assign isMaster = ctrl_reg[spi_ctrl_pkg::BIT_EN] &&
    (mode == spi_ctrl_pkg::MODE_MST_TMR || mode == spi_ctrl_pkg::MODE_MST_DIV);
  assign isSlave = ctrl_reg[spi_ctrl_pkg::BIT_EN] &&
    (mode == spi_ctrl_pkg::MODE_SLV_NOSS || mode == spi_ctrl_pkg::MODE_SLV_SS);
  // slave select only matters in the gated slave mode
  assign ssGate = (mode == spi_ctrl_pkg::MODE_SLV_SS) ? !slaveSelN : 1'b1;
  assign access = psel && penable && !pready_reg;
  assign wrData = access && pwrite && paddr == spi_ctrl_pkg::ADDR_DATA;
  assign rdData = access && !pwrite && paddr == spi_ctrl_pkg::ADDR_DATA;
  spi_clock_gen u_clk (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clkEn(clkEn),
    .run(isMaster && st_reg == spi_ctrl_pkg::ST_SHIFT),
    .useTimer(mode == spi_ctrl_pkg::MODE_MST_TMR),
    .timerPulse(timerPulse),
    .halfTick(halfTick)
  );
  // ---------------------------------------------------------------
  // serial clock edges: leading edge samples, trailing edge shifts
  // ---------------------------------------------------------------
  always_comb begin
    sckEdge = isMaster ? halfTick : (isSlave && ssGate && sckIn != sckInOld_reg);
    // leading edge leaves the idle level
    if (isMaster)
      sampleEdge = halfTick && sckOut_reg == ctrl_reg[spi_ctrl_pkg::BIT_CKP];
    else
      sampleEdge = sckEdge && sckInOld_reg == ctrl_reg[spi_ctrl_pkg::BIT_CKP];
    shiftEdge = sckEdge && !sampleEdge;
  end
  // ---------------------------------------------------------------
  // shifter, buffer and status
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    rxBuf_next = rxBuf_reg;
    bufFull_next = bufFull_reg && !rdData;
    sckOut_next = sckOut_reg;
    sdo_next = sdo_reg;
    sckInOld_next = sckIn;
    stat_next = stat_reg;
    ctrl_next = ctrl_reg;
    if (!ctrl_reg[spi_ctrl_pkg::BIT_EN] || st_reg == spi_ctrl_pkg::ST_IDLE)
      sckOut_next = ctrl_reg[spi_ctrl_pkg::BIT_CKP];
    // software writes first so hardware sets win
    if (access && pwrite && paddr == spi_ctrl_pkg::ADDR_CTRL)
      ctrl_next = pwdata[7:0] & (ctrl_reg | spi_ctrl_pkg::CTRL_WMASK);
    if (access && pwrite && paddr == spi_ctrl_pkg::ADDR_ICLR)
      stat_next = stat_reg & ~pwdata[IW-1:0];
    case (st_reg)
      spi_ctrl_pkg::ST_IDLE: begin
        if (wrData && ctrl_reg[spi_ctrl_pkg::BIT_EN]) begin
          shift_next = pwdata[7:0];
          sdo_next = pwdata[7];
          bitCnt_next = 3'h0;
          st_next = spi_ctrl_pkg::ST_SHIFT;
        end
        // the edge that wakes an idle slave may already be a sampling edge
        if (isSlave && ssGate && sckEdge) begin
          st_next = spi_ctrl_pkg::ST_SHIFT;
          sdo_next = shift_reg[7];
          bitCnt_next = 3'h0;
          if (sampleEdge) begin
            shift_next = {shift_reg[6:0], sdi};
            bitCnt_next = 3'h1;
          end
        end
      end
      spi_ctrl_pkg::ST_SHIFT: begin
        if (wrData) begin
          ctrl_next[spi_ctrl_pkg::BIT_COLL] = 1'b1;
          stat_next[spi_ctrl_pkg::IRQ_COLL] = 1'b1;
        end
        if (isMaster && halfTick)
          sckOut_next = !sckOut_reg;
        if (sampleEdge) begin
          shift_next = {shift_reg[6:0], sdi};
          bitCnt_next = bitCnt_reg + 3'h1;
          if (bitCnt_reg == 3'h7)
            st_next = spi_ctrl_pkg::ST_DONE;
        end else if (shiftEdge) begin
          sdo_next = shift_reg[7];
        end
        if (!ctrl_reg[spi_ctrl_pkg::BIT_EN])
          st_next = spi_ctrl_pkg::ST_IDLE;
      end
      spi_ctrl_pkg::ST_DONE: begin
        // a full buffer in slave mode loses the new byte
        if (bufFull_reg && !rdData && isSlave) begin
          ctrl_next[spi_ctrl_pkg::BIT_OVF] = 1'b1;
          stat_next[spi_ctrl_pkg::IRQ_OVF] = 1'b1;
        end else begin
          rxBuf_next = shift_reg;
          bufFull_next = 1'b1;
        end
        stat_next[spi_ctrl_pkg::IRQ_DONE] = 1'b1;
        st_next = spi_ctrl_pkg::ST_IDLE;
      end
      default: st_next = spi_ctrl_pkg::ST_IDLE;
    endcase
  end
  // ---------------------------------------------------------------
  // apb slave: one wait state, unmapped addresses error
  // ---------------------------------------------------------------
  always_comb begin
    prdata_next = 32'h0000_0000;
    pslverr_next = 1'b0;
    pready_next = psel && penable && !pready_reg;
    ien_next = ien_reg;
    if (access) begin
      if (paddr == spi_ctrl_pkg::ADDR_CTRL) begin
        prdata_next = {24'h000000, ctrl_reg};
      end else if (paddr == spi_ctrl_pkg::ADDR_DATA) begin
        prdata_next = {24'h000000, rxBuf_reg};
      end else if (paddr == spi_ctrl_pkg::ADDR_STAT) begin
        prdata_next = {{(32-IW){1'b0}}, stat_reg};
      end else if (paddr == spi_ctrl_pkg::ADDR_IEN) begin
        prdata_next = {{(32-IW){1'b0}}, ien_reg};
        if (pwrite)
          ien_next = pwdata[IW-1:0];
      end else if (paddr == spi_ctrl_pkg::ADDR_ICLR) begin
        prdata_next = 32'h0000_0000;
      end else begin
        pslverr_next = 1'b1;
      end
    end
    irq_next = |(stat_next & ien_next);
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= spi_ctrl_pkg::CTRL_RESET;
      rxBuf_reg <= 8'h00;
      shift_reg <= 8'h00;
      bitCnt_reg <= 3'h0;
      bufFull_reg <= 1'b0;
      sckOut_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sckInOld_reg <= 1'b0;
      stat_reg <= '0;
      ien_reg <= '0;
      prdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      st_reg <= spi_ctrl_pkg::ST_IDLE;
    end else if (clkEn) begin
      ctrl_reg <= ctrl_next;
      rxBuf_reg <= rxBuf_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      bufFull_reg <= bufFull_next;
      sckOut_reg <= sckOut_next;
      sdo_reg <= sdo_next;
      sckInOld_reg <= sckInOld_next;
      stat_reg <= stat_next;
      ien_reg <= ien_next;
      prdata_reg <= prdata_next;
      irq_reg <= irq_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      st_reg <= st_next;
    end
  end
  // pin directions stay with software, only the enable is exported
  assign portEnable = ctrl_reg[spi_ctrl_pkg::BIT_EN];
  assign sckOut = sckOut_reg;
  assign sdo = sdo_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_mode_field;
    @(posedge clk_sys) disable iff (!resetn)
      (clkEn && access && pwrite && paddr == spi_ctrl_pkg::ADDR_CTRL) |=> mode == $past(pwdata[3:0]);
  endproperty
  a_mode_field: assert property (p_mode_field) else $error("mode field not written");
  property p_idle_level;
    @(posedge clk_sys) disable iff (!resetn)
      (st_reg == spi_ctrl_pkg::ST_IDLE && $stable(ctrl_reg) && $past(st_reg) == spi_ctrl_pkg::ST_IDLE)
        |-> sckOut == ctrl_reg[spi_ctrl_pkg::BIT_CKP];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("serial clock idle level wrong");
  property p_ss_gate;
    @(posedge clk_sys) disable iff (!resetn)
      (clkEn && mode == spi_ctrl_pkg::MODE_SLV_SS && slaveSelN && st_reg == spi_ctrl_pkg::ST_IDLE && !wrData)
        |=> st_reg == spi_ctrl_pkg::ST_IDLE;
  endproperty
  a_ss_gate: assert property (p_ss_gate) else $error("slave ran while deselected");
  property p_noss;
    @(posedge clk_sys) disable iff (!resetn)
      (clkEn && isSlave && mode == spi_ctrl_pkg::MODE_SLV_NOSS && st_reg == spi_ctrl_pkg::ST_IDLE && sckEdge)
        |=> st_reg == spi_ctrl_pkg::ST_SHIFT;
  endproperty
  a_noss: assert property (p_noss) else $error("slave without select did not start");
  property p_div;
    @(posedge clk_sys) disable iff (!resetn)
      (clkEn && mode == spi_ctrl_pkg::MODE_MST_DIV && halfTick) ##1 (clkEn && isMaster)[*8] |-> !halfTick;
  endproperty
  a_div: assert property (p_div) else $error("divided clock too fast");
  property p_tmr;
    @(posedge clk_sys) disable iff (!resetn)
      (isMaster && mode == spi_ctrl_pkg::MODE_MST_TMR && st_reg == spi_ctrl_pkg::ST_SHIFT) |-> halfTick == timerPulse;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer clock not followed");
  property p_coll;
    @(posedge clk_sys) disable iff (!resetn)
      (clkEn && wrData && st_reg == spi_ctrl_pkg::ST_SHIFT)
        |=> ctrl_reg[spi_ctrl_pkg::BIT_COLL] && stat_reg[spi_ctrl_pkg::IRQ_COLL];
  endproperty
  a_coll: assert property (p_coll) else $error("collision not flagged");
  property p_pready;
    @(posedge clk_sys) disable iff (!resetn)
      (clkEn && psel && penable && !pready) |=> pready;
  endproperty
  a_pready: assert property (p_pready) else $error("apb answer late");
  c_master: cover property (@(posedge clk_sys) disable iff (!resetn) isMaster && st_reg == spi_ctrl_pkg::ST_DONE);
  c_slave: cover property (@(posedge clk_sys) disable iff (!resetn) isSlave && st_reg == spi_ctrl_pkg::ST_DONE);
  c_ovf: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(ctrl_reg[spi_ctrl_pkg::BIT_OVF]));
endmodule : sync_serial_spi_control
`default_nettype wire

//--- bench/spi_peer_model.sv
// far-side spi peer: answers a master port, or plays master to a slave port
// assumes the bench starts each frame just after a clk_sys edge
`timescale 1ns/100ps
`default_nettype none
module spi_peer_model (
  input wire logic clk_sys,
  input wire logic clock_idle_polarity,
  input wire logic sckOut,
  input wire logic sdo,
  output logic sckIn,
  output logic sdi,
  output logic slaveSelN
);
  // ---------------------------------------------------------------
  // shifters
  // ---------------------------------------------------------------
  logic [7:0] txByte;
  logic [7:0] rxByte;
  logic sckPrev;
  initial begin
    txByte = 8'h00;
    rxByte = 8'h00;
    sckPrev = 1'b0;
    sckIn = 1'b0;
    slaveSelN = 1'b1;
  end
  // fill with the inverse bit so a stale data line never looks valid
  assign sdi = txByte[7];
  // slave role: sample on the leading edge, shift on the trailing edge
  always @(posedge clk_sys) begin
    sckPrev <= sckOut;
    if (sckOut !== sckPrev && sckOut !== clock_idle_polarity) rxByte <= {rxByte[6:0], sdo};
    if (sckOut !== sckPrev && sckOut === clock_idle_polarity) txByte <= {txByte[6:0], ~txByte[0]};
  end
  task automatic load(input logic [7:0] v);
    txByte <= v;
  endtask : load
  // master role: eight bits msb first, clock idles at ckp between frames
  task automatic frame(input logic [7:0] v, input logic ssLow);
    @(posedge clk_sys);
    txByte <= v;
    slaveSelN <= ~ssLow;
    sckIn <= clock_idle_polarity;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      sckIn <= ~clock_idle_polarity;
      rxByte <= {rxByte[6:0], sdo};
      repeat (4) @(posedge clk_sys);
      sckIn <= clock_idle_polarity;
      txByte <= {txByte[6:0], ~txByte[0]};
      repeat (4) @(posedge clk_sys);
    end
    slaveSelN <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : frame
endmodule : spi_peer_model
`default_nettype wire

//--- bench/sync_serial_spi_control_tb.sv
// self-checking bench for the serial port control block
// assumes the peer model on the serial pins and apb on clk_sys
`timescale 1ns/100ps
`default_nettype none
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module sync_serial_spi_control_tb;
  // ---------------------------------------------------------------
  // environment
  // ---------------------------------------------------------------
  localparam logic [11:0] CT = spi_ctrl_pkg::ADDR_CTRL;
  localparam logic [11:0] DA = spi_ctrl_pkg::ADDR_DATA;
  localparam logic [11:0] ST = spi_ctrl_pkg::ADDR_STAT;
  localparam logic [11:0] IE = spi_ctrl_pkg::ADDR_IEN;
  localparam logic [11:0] IC = spi_ctrl_pkg::ADDR_ICLR;
  localparam int TPER = 5;
  localparam logic [32:0] ERR = 33'h1_0000_0000;
  logic clk_sys, resetn, clkEn, psel, penable, pwrite, timerPulse, pready, pslverr;
  logic sckIn, sdi, slaveSelN, sckOut, sdo, portEnable, irq, clock_idle_polarity;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] expQ[$], maskQ[$], mE, mM;
  logic [7:0] b, pb;
  logic [3:0] mode;
  int errors, total_checks, tcnt, n, c;
  sync_serial_spi_control sync_serial_spi_control_inst (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerPulse(timerPulse), .sckIn(sckIn), .sdi(sdi),
    .slaveSelN(slaveSelN), .sckOut(sckOut), .sdo(sdo), .portEnable(portEnable), .irq(irq));
  spi_peer_model spi_peer_model_inst (.clk_sys(clk_sys), .clock_idle_polarity(clock_idle_polarity), .sckOut(sckOut), .sdo(sdo),
    .sckIn(sckIn), .sdi(sdi), .slaveSelN(slaveSelN));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // second timer stand-in: one pulse every TPER clocks
  always @(posedge clk_sys) begin
    tcnt <= (tcnt == TPER - 1) ? 0 : tcnt + 1;
    timerPulse <= (tcnt == TPER - 1);
  end
  // answer watcher: oldest note against each completed transfer
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) begin
      mE = expQ.pop_front();
      mM = maskQ.pop_front();
      `CHECK({pslverr, prdata} & mM, mE & mM)
    end
  end
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e,
                      input logic [32:0] m);
    expQ.push_back(e);
    maskQ.push_back(m);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0, ERR);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    xfer(1'b0, a, 32'h0, e, m);
  endtask : rd
  // bounded waits on the interrupt line and on serial clock changes
  task automatic waitIrq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    `CHECK(irq, 1'b1)
  endtask : waitIrq
  task automatic halfPeriod();
    logic s0;
    s0 = sckOut;
    c = 0;
    while (sckOut === s0 && c < 200) begin
      @(posedge clk_sys);
      c++;
    end
  endtask : halfPeriod
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {clkEn, resetn, psel, penable, pwrite, timerPulse, clock_idle_polarity} = 7'b1000000;
    {paddr, pwdata, tcnt, errors, total_checks} = '0;
    b = 8'($urandom(32'h533a));
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(CT, 33'h0, 33'hff);
    rd(ST, 33'h0, 33'h7);
    rd(12'h014, ERR, ERR);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      clock_idle_polarity = i[0];
      mode = 4'h2 + 4'(i[2:1]);
      wr(CT, {24'h0, 3'b111, clock_idle_polarity, mode});
      rd(CT, {27'h0, 1'b1, clock_idle_polarity, mode}, 33'hff);
      `CHECK(portEnable, 1'b1)
      if (!mode[2]) `CHECK(sckOut, clock_idle_polarity)
    end
    $display("test modes done");
    b = 8'($urandom());
    pb = 8'($urandom());
    clock_idle_polarity = 1'($urandom());
    wr(IE, 32'h4);
    wr(CT, {24'h0, 3'b001, clock_idle_polarity, 4'h2});
    // let the peer see the new idle level before loading it
    @(posedge clk_sys);
    spi_peer_model_inst.load(pb);
    wr(DA, {24'h0, b});
    halfPeriod();
    halfPeriod();
    `CHECK(c, spi_ctrl_pkg::FOSC_DIV / 2)
    waitIrq(2000);
    `CHECK(spi_peer_model_inst.rxByte, b)
    rd(DA, {25'h0, pb}, 33'hff);
    rd(ST, 33'h4, 33'h7);
    wr(IC, 32'h7);
    `CHECK(irq, 1'b0)
    $display("test divided master done");
    clock_idle_polarity = 1'b0;
    wr(IE, 32'h1);
    wr(CT, 32'h23);
    @(posedge clk_sys);
    spi_peer_model_inst.load(pb);
    wr(DA, {24'h0, b});
    halfPeriod();
    halfPeriod();
    `CHECK(c, TPER)
    wr(DA, 32'h5a);
    waitIrq(20);
    rd(ST, 33'h1, 33'h1);
    rd(CT, 33'ha3, 33'hff);
    wr(CT, 32'h23);
    rd(CT, 33'h23, 33'hff);
    wr(IC, 32'h1);
    wr(IE, 32'h4);
    waitIrq(300);
    rd(DA, {25'h0, pb}, 33'hff);
    $display("test timer master done");
    for (int i = 0; i < 3; i++) begin
      mode = (i == 2) ? 4'h5 : 4'h4;
      b = 8'($urandom());
      wr(IC, 32'h7);
      wr(IE, 32'h0);
      wr(CT, {24'h0, 4'h2, mode});
      spi_peer_model_inst.frame(b, i == 0);
      rd(ST, {30'h0, i != 1, 2'b00}, 33'h4);
      `CHECK(irq, 1'b0)
      wr(IE, 32'h4);
      `CHECK(irq, 1'(i != 1))
      if (i != 1) rd(DA, {25'h0, b}, 33'hff);
    end
    spi_peer_model_inst.frame(b, 1'b0);
    spi_peer_model_inst.frame(b, 1'b0);
    rd(ST, 33'h2, 33'h2);
    rd(CT, 33'h40, 33'h40);
    $display("test slave done");
    final_report();
  end
endmodule : sync_serial_spi_control_tb
`default_nettype wire
